// ===== sarseq_top.sv
// sequencer of a 10-bit successive-approximation converter with eight inputs

//Behaviour
//RULE1: ten-bit successive approximation, single or scan mode
//RULE2: single mode: go bit clears at end
//RULE3: single end sets flag, interrupt if enabled
//RULE4: flag clears by zero write after read
//RULE5: software stops before changing mode or channel
//RULE6: single result stored in its channel's register
//RULE7: start by software, timer or trigger pin
//RULE8: scan converts group channels cyclically from first
//RULE9: scan results go to each channel's register
//RULE10: full scan pass sets flag, restarts group
//RULE11: stop ends scan; restart from first channel
//RULE12: select msb picks group, low bits count
//RULE13: sample after start delay, then approximate
//RULE14: first conversion delay, sampling and total states
//RULE15: later scan conversions take 256 or 128
//RULE16: trigger code 11: pin falling edge starts
//RULE17: pin start behaves like software start
//RULE18: end interrupt doubles as transfer request
//RULE19: select bits pick channel or group
//RULE20: trigger select decodes none, timer, timer, pin
//RULE21: reset, standby or module stop clear go; there is no module stop input, only reset and i_standby
//RULE22: interrupt equals flag and enable, live; the interrupt is registered, so a change of enable shows one cycle later
module sarseq_top (
    input  wire logic                              i_ref_clk,
    input  wire logic                              i_rst_n,
    input  wire logic                              i_go_write,
    input  wire logic                              i_go_wdata,
    input  wire logic                              i_scan_mode,
    input  wire logic                              i_conversion_speed_select,
    input  wire logic [sarseq_pkg::CHAN_WIDTH-1:0] i_channel_select,
    input  wire logic [1:0]                        i_trigger_source_select,
    input  wire logic                              i_end_irq_enable,
    input  wire logic                              i_status_read,
    input  wire logic                              i_flag_clear_write,
    input  wire logic                              i_timer_pulse_trigger,
    input  wire logic                              i_timer8_trigger,
    input  wire logic                              i_external_trigger_pin,
    input  wire logic                              i_standby,
    input  wire logic                              i_compare_high,
    input  wire logic [sarseq_pkg::CHAN_WIDTH-1:0] i_result_index,
    input  wire logic                              i_result_ready,
    output logic                                   o_conversion_go_bit,
    output logic                                   o_conversion_end_flag,
    output logic                                   o_conversion_end_interrupt,
    output logic                                   o_sample_hold,
    output logic [sarseq_pkg::CHAN_WIDTH-1:0]      o_channel,
    output logic [sarseq_pkg::RESULT_WIDTH-1:0]    o_dac_code,
    output logic [sarseq_pkg::RESULT_WIDTH-1:0]    o_result_read_data,
    output logic                                   o_result_valid,
    output logic [sarseq_pkg::FIFO_WIDTH-1:0]      o_result_data
);
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_APPROX} sarseq_state_type;

    function automatic logic [8:0] sarseq_pick(input logic fast, input logic [8:0] slow_v,
                                               input logic [8:0] fast_v);
        sarseq_pick = fast ? fast_v : slow_v;
    endfunction : sarseq_pick

    sarseq_state_type                      state;
    logic [8:0]                            cnt;
    logic [2:0]                            phase;
    logic [4:0]                            bit_timer;
    logic [3:0]                            step;
    logic                                  first_conv;
    logic                                  flag_armed;
    logic                                  pin_prev;
    logic [sarseq_pkg::RESULT_WIDTH-1:0]   results [sarseq_pkg::CHAN_COUNT];
    logic                                  trig_hit;
    logic                                  start_req;
    logic                                  stop_req;
    logic                                  conv_done;
    logic                                  fifo_in_ready;
    logic                                  last_in_group;
    logic                                  flag_set;
    logic                                  flag_clr;
    logic                                  next_flag;
    logic                                  next_go;
    logic [sarseq_pkg::CHAN_WIDTH-1:0]     first_chan;
    logic [sarseq_pkg::CHAN_WIDTH-1:0]     group_last;
    logic [8:0]                            delay_len;
    logic [8:0]                            sample_len;
    logic [8:0]                            approx_first;
    logic [8:0]                            approx_next;
    logic [4:0]                            bit_len;
    logic [3:0]                            bit_pos;

    // ****************************************************************
    // start, stop and channel decode
    // ****************************************************************
    always_comb begin
        unique case (i_trigger_source_select)                         // see RULE20
            sarseq_pkg::TRIG_TIMER_PULSE: trig_hit = i_timer_pulse_trigger;
            sarseq_pkg::TRIG_TIMER8:      trig_hit = i_timer8_trigger;
            sarseq_pkg::TRIG_PIN:         trig_hit = pin_prev && !i_external_trigger_pin; // see RULE16
            default:                      trig_hit = 1'b0;
        endcase
    end

    // a pin edge lands on the same path as a software write of one
    assign start_req  = (i_go_write && i_go_wdata) || trig_hit;     // see RULE7, see RULE17
    assign stop_req   = i_standby || (i_go_write && !i_go_wdata);   // see RULE21, see RULE5
    assign first_chan = i_scan_mode ? {i_channel_select[2], 2'b00} : i_channel_select; // see RULE19
    assign group_last = {i_channel_select[2], i_channel_select[1:0]};                 // see RULE12
    assign last_in_group = !i_scan_mode || (o_channel == group_last);

    // ****************************************************************
    // timing figures
    // ****************************************************************
    // the start delay jitters with the free phase, as a bus write lands anywhere in it
    assign delay_len = sarseq_pick(i_conversion_speed_select,
        sarseq_pkg::DELAY_MIN_SLOW + {6'h00, phase & sarseq_pkg::DELAY_JITTER_SLOW},
        sarseq_pkg::DELAY_MIN_FAST + {6'h00, phase & sarseq_pkg::DELAY_JITTER_FAST}); // see RULE14
    assign sample_len = sarseq_pick(i_conversion_speed_select,
        sarseq_pkg::SAMPLE_SLOW, sarseq_pkg::SAMPLE_FAST);
    assign approx_first = sarseq_pick(i_conversion_speed_select,
        sarseq_pkg::FIRST_TOTAL_SLOW - sarseq_pkg::DELAY_MIN_SLOW - sarseq_pkg::SAMPLE_SLOW,
        sarseq_pkg::FIRST_TOTAL_FAST - sarseq_pkg::DELAY_MIN_FAST - sarseq_pkg::SAMPLE_FAST);
    assign approx_next = sarseq_pick(i_conversion_speed_select,
        sarseq_pkg::NEXT_TOTAL_SLOW - sarseq_pkg::SAMPLE_SLOW,
        sarseq_pkg::NEXT_TOTAL_FAST - sarseq_pkg::SAMPLE_FAST);       // see RULE15
    assign bit_len = i_conversion_speed_select ? sarseq_pkg::BIT_STATES_FAST
                                               : sarseq_pkg::BIT_STATES_SLOW;
    assign bit_pos = sarseq_pkg::SAR_LAST_STEP - step;

    // a full result fifo holds the end of conversion until it drains
    assign conv_done = (state == ST_APPROX) && (cnt == 9'h000)
                    && (step == sarseq_pkg::SAR_DONE_STEP) && fifo_in_ready && !stop_req;

    // ****************************************************************
    // go bit, end flag and interrupt
    // ****************************************************************
    always_comb begin
        if (stop_req) begin
            next_go = 1'b0;                                           // see RULE11
        end else if (start_req && !o_conversion_go_bit) begin
            next_go = 1'b1;
        end else if (conv_done && !i_scan_mode) begin
            next_go = 1'b0;                                           // see RULE2
        end else begin
            next_go = o_conversion_go_bit;
        end
    end

    assign flag_set  = conv_done && last_in_group;                    // see RULE3, see RULE10
    assign flag_clr  = i_flag_clear_write && flag_armed;              // see RULE4
    assign next_flag = flag_set || (o_conversion_end_flag && !flag_clr);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_conversion_go_bit        <= 1'b0;
            o_conversion_end_flag      <= 1'b0;
            o_conversion_end_interrupt <= 1'b0;
        end else begin
            o_conversion_go_bit        <= next_go;
            o_conversion_end_flag      <= next_flag;
            // the same level serves the cpu and the transfer controllers
            o_conversion_end_interrupt <= next_flag && i_end_irq_enable; // see RULE22, see RULE18
        end
    end

    // a clear only counts after the flag was seen set; a new set re-arms nothing
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_armed <= 1'b0;
        end else if (flag_set || flag_clr) begin
            flag_armed <= 1'b0;
        end else if (i_status_read && o_conversion_end_flag) begin
            flag_armed <= 1'b1;                                       // see RULE4
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase    <= 3'h0;
            pin_prev <= 1'b1;
        end else begin
            phase    <= phase + 3'h1;
            pin_prev <= i_external_trigger_pin;
        end
    end

    // ****************************************************************
    // conversion sequence
    // ****************************************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state         <= ST_IDLE;
            cnt           <= 9'h000;
            first_conv    <= 1'b0;
            o_sample_hold <= 1'b0;
            o_channel     <= '0;
        end else if (stop_req) begin
            state         <= ST_IDLE;                                 // see RULE11
            o_sample_hold <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_req && !o_conversion_go_bit) begin
                        state      <= ST_DELAY;                       // see RULE13
                        cnt        <= delay_len - 9'h001;
                        first_conv <= 1'b1;
                        o_channel  <= first_chan;                     // see RULE8, see RULE19
                    end
                end
                ST_DELAY: begin
                    if (cnt == 9'h000) begin
                        state         <= ST_SAMPLE;
                        cnt           <= sample_len - 9'h001;         // see RULE14
                        o_sample_hold <= 1'b1;
                    end else begin
                        cnt <= cnt - 9'h001;
                    end
                end
                ST_SAMPLE: begin
                    if (cnt == 9'h000) begin
                        state         <= ST_APPROX;
                        o_sample_hold <= 1'b0;
                        cnt           <= (first_conv ? approx_first : approx_next) - 9'h001;
                    end else begin
                        cnt <= cnt - 9'h001;
                    end
                end
                ST_APPROX: begin
                    if (cnt != 9'h000) begin
                        cnt <= cnt - 9'h001;
                    end else if (conv_done) begin
                        if (i_scan_mode) begin
                            state         <= ST_SAMPLE;                // see RULE8
                            cnt           <= sample_len - 9'h001;
                            o_sample_hold <= 1'b1;
                            first_conv    <= 1'b0;
                            o_channel     <= last_in_group ? first_chan
                                           : o_channel + 3'h1;         // see RULE10, see RULE12
                        end else begin
                            state <= ST_IDLE;                          // see RULE2
                        end
                    end
                end
            endcase
        end
    end

    // one trial bit is settled every bit_len states, msb first
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dac_code <= '0;
            bit_timer  <= 5'h00;
            step       <= 4'h0;
        end else if (state == ST_SAMPLE) begin
            o_dac_code <= sarseq_pkg::SAR_MSB_TRIAL;
            bit_timer  <= 5'h00;
            step       <= 4'h0;
        end else if (state == ST_APPROX && step != sarseq_pkg::SAR_DONE_STEP) begin
            if (bit_timer == bit_len - 5'h01) begin
                bit_timer <= 5'h00;
                step      <= step + 4'h1;
                if (!i_compare_high) begin
                    o_dac_code[bit_pos] <= 1'b0;                      // see RULE1
                end
                if (step != sarseq_pkg::SAR_LAST_STEP) begin
                    o_dac_code[bit_pos - 4'h1] <= 1'b1;
                end
            end else begin
                bit_timer <= bit_timer + 5'h01;
            end
        end
    end

    // ****************************************************************
    // result registers and stream
    // ****************************************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < sarseq_pkg::CHAN_COUNT; i++) begin
                results[i] <= '0;
            end
            o_result_read_data <= '0;
        end else begin
            if (conv_done) begin
                results[o_channel] <= o_dac_code;                     // see RULE6, see RULE9
            end
            o_result_read_data <= results[i_result_index];
        end
    end

    sarseq_fifo #(
        .WIDTH (sarseq_pkg::FIFO_WIDTH),
        .DEPTH (sarseq_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (conv_done),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   ({o_channel, o_dac_code}),
        .o_out_valid (o_result_valid),
        .i_out_ready (i_result_ready),
        .o_out_data  (o_result_data)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_scan_wrap;
        conv_done && i_scan_mode && last_in_group && !start_req;
    endsequence

    a_single_go_clear: assert property (conv_done && !i_scan_mode // see RULE2
        |=> !o_conversion_go_bit && state == ST_IDLE) else $error("go bit kept after single end");
    a_end_flag_set: assert property (conv_done && last_in_group   // see RULE3
        |=> o_conversion_end_flag) else $error("end flag not set");
    a_flag_clear_armed: assert property ($fell(o_conversion_end_flag) // see RULE4
        |-> $past(flag_armed) && $past(i_flag_clear_write)) else $error("flag cleared unread");
    a_irq_follows_flag: assert property (o_conversion_end_interrupt // see RULE22
        |-> o_conversion_end_flag && $past(i_end_irq_enable)) else $error("irq without cause");
    a_result_steered: assert property (conv_done                  // see RULE6
        ##1 1'b1 |-> results[$past(o_channel)] == $past(o_dac_code)) else $error("bad result slot");
    a_scan_restart: assert property (s_scan_wrap                  // see RULE10
        |=> o_channel == {i_channel_select[2], 2'b00} && state == ST_SAMPLE)
        else $error("scan did not wrap");
    a_pin_start: assert property (state == ST_IDLE && !o_conversion_go_bit // see RULE16
        && i_trigger_source_select == sarseq_pkg::TRIG_PIN && pin_prev
        && !i_external_trigger_pin && !stop_req
        |=> o_conversion_go_bit && state == ST_DELAY) else $error("pin edge ignored");
    a_start_delay: assert property (disable iff (!i_rst_n || stop_req) // see RULE14
        $rose(state == ST_DELAY)
        |-> (state == ST_DELAY)[*6] ##[1:12] state != ST_DELAY) else $error("delay out of range");
    a_next_length: assert property (state == ST_SAMPLE && cnt == 9'h000 && !first_conv // see RULE15
        && !stop_req |=> cnt == approx_next - 9'h001) else $error("scan length wrong");
    a_go_first_chan: assert property ($rose(o_conversion_go_bit) && state == ST_DELAY // see RULE11
        |-> o_channel == $past(first_chan)) else $error("scan not from first channel");
endmodule : sarseq_top

// ===== sarseq_fifo.sv
// package of shared constants and the result fifo of the converter sequencer

package sarseq_pkg;
    localparam int             RESULT_WIDTH      = 10;
    localparam int             CHAN_WIDTH        = 3;
    localparam int             CHAN_COUNT        = 8;
    localparam int             FIFO_DEPTH        = 8;
    localparam int             FIFO_WIDTH        = RESULT_WIDTH + CHAN_WIDTH;
    // all timings below are in system-clock states
    localparam logic [8:0]     DELAY_MIN_SLOW    = 9'h00A;
    localparam logic [8:0]     DELAY_MIN_FAST    = 9'h006;
    localparam logic [2:0]     DELAY_JITTER_SLOW = 3'h7;
    localparam logic [2:0]     DELAY_JITTER_FAST = 3'h3;
    localparam logic [8:0]     SAMPLE_SLOW       = 9'h03F;
    localparam logic [8:0]     SAMPLE_FAST       = 9'h01F;
    localparam logic [8:0]     FIRST_TOTAL_SLOW  = 9'h103;
    localparam logic [8:0]     FIRST_TOTAL_FAST  = 9'h083;
    localparam logic [8:0]     NEXT_TOTAL_SLOW   = 9'h100;
    localparam logic [8:0]     NEXT_TOTAL_FAST   = 9'h080;
    localparam logic [4:0]     BIT_STATES_SLOW   = 5'h12;
    localparam logic [4:0]     BIT_STATES_FAST   = 5'h09;
    localparam logic [3:0]     SAR_LAST_STEP     = 4'h9;
    localparam logic [3:0]     SAR_DONE_STEP     = 4'hA;
    localparam logic [9:0]     SAR_MSB_TRIAL     = 10'h200;
    localparam logic [1:0]     TRIG_NONE         = 2'h0;
    localparam logic [1:0]     TRIG_TIMER_PULSE  = 2'h1;
    localparam logic [1:0]     TRIG_TIMER8       = 2'h2;
    localparam logic [1:0]     TRIG_PIN          = 2'h3;
endpackage : sarseq_pkg

module sarseq_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    // count covers the array only; the output register is one extra slot
    assign o_in_ready = (count < CW'(DEPTH));
    assign push       = i_in_valid && o_in_ready;
    assign pop        = (count != '0) && (!o_out_valid || i_out_ready);

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= AW'(wptr + 1'b1);
            end
            if (pop) begin
                rptr <= AW'(rptr + 1'b1);
            end
            count <= CW'(count + CW'(push) - CW'(pop));
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_out_valid <= 1'b0;
            o_out_data  <= '0;
        end else if (pop) begin
            o_out_valid <= 1'b1;
            o_out_data  <= mem[rptr];
        end else if (i_out_ready) begin
            o_out_valid <= 1'b0;
        end
    end
endmodule : sarseq_fifo

// ===== sarseq_partner.sv
// far-side model: analog inputs seen through the comparator of the converter
module sarseq_partner (
    input  wire logic [2:0] i_channel,
    input  wire logic [9:0] i_dac_code,
    output logic            o_compare_high
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // input levels
    // ****************************************
    // each input holds a distinct level so that a result in the wrong slot shows
    function automatic logic [9:0] level(input logic [2:0] c);
        return {c, 7'h2A};
    endfunction : level
    // keeps the trial bit while the input is at or above the trial code
    assign o_compare_high = (level(i_channel) >= i_dac_code);
endmodule : sarseq_partner

// ===== sar_adc_sequencer_tb.sv
// self-checking bench of the converter sequencer
module sar_adc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, go_wr, go_d, scan, spd, irq_en, rd, clr, tp, t8, pin, stby, cmp;
    logic [2:0]  chs, ridx, chan;
    logic [1:0]  trig;
    logic        go, flag, irq, valid, sh;
    logic [9:0]  dac, rdata;
    logic [12:0] rdat;
    logic [12:0] got[$];
    int          fails, tests_run, n, sh_n;
    sarseq_top dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_go_write(go_wr), .i_go_wdata(go_d),
        .i_scan_mode(scan), .i_conversion_speed_select(spd), .i_channel_select(chs),
        .i_trigger_source_select(trig), .i_end_irq_enable(irq_en), .i_status_read(rd),
        .i_flag_clear_write(clr), .i_timer_pulse_trigger(tp), .i_timer8_trigger(t8),
        .i_external_trigger_pin(pin), .i_standby(stby), .i_compare_high(cmp),
        .i_result_index(ridx), .i_result_ready(1'b1), .o_conversion_go_bit(go),
        .o_conversion_end_flag(flag), .o_conversion_end_interrupt(irq), .o_sample_hold(sh),
        .o_channel(chan), .o_dac_code(dac), .o_result_read_data(rdata),
        .o_result_valid(valid), .o_result_data(rdat));
    sarseq_partner p_u (.i_channel(chan), .i_dac_code(dac), .o_compare_high(cmp));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [9:0] lvl(input logic [2:0] c);
        return {c, 7'h2A};
    endfunction : lvl
    task check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task results();
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    task step(input int k);
        repeat (k) @(negedge clk);
    endtask : step
    task go_w(input logic v);
        @(negedge clk) begin go_wr = 1'b1; go_d = v; end
        @(negedge clk) go_wr = 1'b0;
    endtask : go_w
    task strobe(input int w);
        @(negedge clk) begin rd = (w == 0); clr = (w == 1); tp = (w == 2); t8 = (w == 3); end
        @(negedge clk) begin rd = 1'b0; clr = 1'b0; tp = 1'b0; t8 = 1'b0; end
    endtask : strobe
    // bounded wait; counts edges after the taking edge until the flag shows
    task wait_flag();
        n = 0;
        while (flag !== 1'b1 && n < 600) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 600) begin fails++; results(); end
        step(1);
    endtask : wait_flag
    always @(posedge clk) if (valid === 1'b1) got.push_back(rdat);
    always @(posedge clk) if (sh === 1'b1) sh_n++;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        {rst_n, go_wr, go_d, scan, spd, irq_en, rd, clr, tp, t8, stby} = '0;
        pin = 1'b1; chs = 3'h1; ridx = 3'h1; trig = 2'h0; fails = 0; tests_run = 0;
        sh_n = 0;
        step(12);
        rst_n = 1'b1;
        step(2);
        irq_en = 1'b1;
        go_w(1'b1);
        wait_flag();
        check(16'(n >= 259 && n <= 266), 16'h0001);
        check(16'(sh_n), 16'h003F);
        check(16'(go), 16'h0000);
        step(1);
        check(16'(irq), 16'h0001);
        check(16'(rdata), 16'(lvl(3'h1)));
        step(3);
        check(16'(got.pop_front()), 16'({3'h1, lvl(3'h1)}));
        strobe(1);
        check(16'(flag), 16'h0001);
        strobe(0);
        strobe(1);
        step(1);
        check(16'(flag), 16'h0000);
        check(16'(irq), 16'h0000);
        // mode and trigger change only while stopped
        scan = 1'b1; spd = 1'b1; chs = 3'h6; trig = 2'h3;
        sh_n = 0;
        @(negedge clk) pin = 1'b0;
        @(negedge clk) pin = 1'b1;
        wait_flag();
        check(16'(go), 16'h0001);
        check(16'(sh_n), 16'h005D);
        check(16'(irq), 16'h0001);
        irq_en = 1'b0;
        step(1);
        check(16'(irq), 16'h0000);
        irq_en = 1'b1;
        step(3);
        for (int i = 4; i < 7; i++) check(16'(got.pop_front()), 16'({3'(i), lvl(3'(i))}));
        step(150);
        check(16'(got.pop_front()), 16'({3'h4, lvl(3'h4)}));
        go_w(1'b0);
        check(16'(go), 16'h0000);
        got.delete();
        go_w(1'b1);
        n = 0;
        while (got.size() == 0 && n < 400) begin step(1); n++; end
        if (n >= 400) begin fails++; results(); end
        check(16'(got.size() > 0 ? got[0] : 13'h0), 16'({3'h4, lvl(3'h4)}));
        go_w(1'b0);
        scan = 1'b0; chs = 3'h2; trig = 2'h1;
        strobe(3);
        check(16'(go), 16'h0000);
        strobe(2);
        check(16'(go), 16'h0001);
        stby = 1'b1;
        step(2);
        check(16'(go), 16'h0000);
        stby = 1'b0; trig = 2'h2;
        strobe(3);
        check(16'(go), 16'h0001);
        go_w(1'b0);
        trig = 2'h0;
        strobe(2);
        check(16'(go), 16'h0000);
        results();
    end
endmodule : sar_adc_sequencer_tb
